// >>> hdl/ivpr_pkg.sv
// Constants and types for the interrupt vector priority resolver
package ivpr_pkg;
  localparam int unsigned IVPR_NUM_VEC = 86;
  localparam int unsigned IVPR_VEC_W = 7;
  localparam int unsigned IVPR_ADDR_W = 21;
  localparam int unsigned IVPR_TARGET_W = 19;
  localparam int unsigned IVPR_LVL_W = 2;
  localparam int unsigned IVPR_WORDS_PER_ENTRY = 2;
  // Table bases at which entries 0 and 1 are the reset overlay
  localparam logic [20:0] IVPR_RESET_BASE_INT = 21'h000200;
  localparam logic [20:0] IVPR_RESET_BASE_EXT = 21'h000000;
  // Vector numbers with a documented fixed role
  localparam logic [6:0] IVPR_VEC_LOW_VOLTAGE = 7'h14;
  localparam logic [6:0] IVPR_VEC_PLL = 7'h15;
  localparam logic [6:0] IVPR_VEC_CONV_B_LIMIT = 7'h4b;
  localparam logic [6:0] IVPR_VEC_CONV_A_LIMIT = 7'h4c;
  localparam logic [6:0] IVPR_VEC_SOFT_LP = 7'h51;
  // Level classes of each vector
  typedef enum logic [2:0] {
    IVPR_CLS_NONE,
    IVPR_CLS_FIX3,
    IVPR_CLS_FIX2,
    IVPR_CLS_FIX1,
    IVPR_CLS_FIX0,
    IVPR_CLS_DBG,
    IVPR_CLS_PER
  } ivpr_cls_t;
  // Class of each vector number
  function automatic ivpr_cls_t ivpr_class(input int unsigned v);
    ivpr_class = IVPR_CLS_PER;
    if (v <= 1 || v == 8 || v == 12 || v == 13 || v == 19 || v == 25 || v == 36 ||
        v == 37 || v == 44 || v == 51 || v == 70 || v >= IVPR_NUM_VEC) begin
      ivpr_class = IVPR_CLS_NONE;
    end else if (v <= 5) begin
      ivpr_class = IVPR_CLS_FIX3;
    end else if (v <= 11) begin
      ivpr_class = IVPR_CLS_DBG;
    end else if (v == 14) begin
      ivpr_class = IVPR_CLS_FIX2;
    end else if (v == 15 || v == 81) begin
      ivpr_class = IVPR_CLS_FIX1;
    end else if (v == 16) begin
      ivpr_class = IVPR_CLS_FIX0;
    end
  endfunction
endpackage

// >>> hdl/ivpr_level_map.sv
// Effective level of one request
`timescale 1ns/100ps
module ivpr_level_map #(
  parameter int unsigned VEC = 2
) (
  input wire logic req_in,
  input wire logic [ivpr_pkg::IVPR_LVL_W-1:0] prog_level_in,
  output logic valid_out,
  output logic [ivpr_pkg::IVPR_LVL_W-1:0] level_out
);
  import ivpr_pkg::*;
  localparam ivpr_cls_t CLS = ivpr_class(VEC);

  // Fold the class rules into a valid flag and a level
  always_comb begin
    valid_out = req_in;
    level_out = prog_level_in;
    unique case (CLS)
      IVPR_CLS_NONE: begin
        valid_out = 1'b0;
        level_out = 2'h0;
      end
      IVPR_CLS_FIX3: level_out = 2'h3;
      IVPR_CLS_FIX2: level_out = 2'h2;
      IVPR_CLS_FIX1: level_out = 2'h1;
      IVPR_CLS_FIX0: level_out = 2'h0;
      // Level 0 is not a debug level, so it disables the source
      IVPR_CLS_DBG: valid_out = req_in && (prog_level_in != 2'h0);
      // Level 3 is reserved for the core, so it disables the source
      IVPR_CLS_PER: valid_out = req_in && (prog_level_in != 2'h3);
    endcase
  end
endmodule // ivpr_level_map

// >>> hdl/ivpr_resolver.sv
// Interrupt priority resolver and vector fetch address generator
`timescale 1ns/100ps
module ivpr_resolver (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [ivpr_pkg::IVPR_NUM_VEC-1:0] req_in,
  input wire logic [2*ivpr_pkg::IVPR_NUM_VEC-1:0] prog_level_in,
  input wire logic [ivpr_pkg::IVPR_LVL_W-1:0] core_mask_in,
  input wire logic [ivpr_pkg::IVPR_ADDR_W-1:0] vector_table_base_in,
  input wire logic ext_boot_in,
  input wire logic ext_address_width_select_in,
  input wire logic ack_in,
  output logic irq_out,
  output logic [ivpr_pkg::IVPR_VEC_W-1:0] vector_out,
  output logic [ivpr_pkg::IVPR_LVL_W-1:0] level_out,
  output logic [ivpr_pkg::IVPR_ADDR_W-1:0] fetch_addr_out,
  output logic reset_overlay_out
);
  import ivpr_pkg::*;

  // The scan, the level maps and the fetch arithmetic assume these sizes
  if (IVPR_LVL_W != 2 || IVPR_ADDR_W < IVPR_VEC_W + 1 ||
      (1 << IVPR_VEC_W) < IVPR_NUM_VEC) begin : g_bad_cfg
    $error("unsupported vector table configuration");
  end

  logic [IVPR_NUM_VEC-1:0] valid;
  logic [2*IVPR_NUM_VEC-1:0] lvl;
  logic win_found;
  logic [IVPR_VEC_W-1:0] win_vec;
  logic [IVPR_LVL_W-1:0] win_lvl;
  logic irq_ff;
  logic [IVPR_VEC_W-1:0] vec_ff;
  logic [IVPR_LVL_W-1:0] lvl_ff;
  logic [IVPR_ADDR_W-1:0] addr_ff;
  logic overlay_ff;
  logic nxt_overlay;
  // Checker helpers: a second view of the winner, read only by assertions
  logic beaten;
  logic [IVPR_LVL_W-1:0] raw_lvl_ff;

  // One level map per vector; reserved ones fold to never valid
  for (genvar g = 0; g < IVPR_NUM_VEC; g++) begin : g_map
    ivpr_level_map #(.VEC(g)) u_map (
      .req_in(req_in[g]),
      .prog_level_in(prog_level_in[2*g +: 2]),
      .valid_out(valid[g]),
      .level_out(lvl[2*g +: 2])
    );
  end

  // Scan from high vector to low so the lowest number wins ties
  always_comb begin
    win_found = 1'b0;
    win_vec = 7'h00;
    win_lvl = 2'h0;
    for (int i = IVPR_NUM_VEC - 1; i >= 0; i--) begin
      if (valid[i] && lvl[2*i +: 2] >= core_mask_in) begin
        if (!win_found || lvl[2*i +: 2] >= win_lvl) begin
          win_found = 1'b1;
          win_vec = IVPR_VEC_W'(i);
          win_lvl = lvl[2*i +: 2];
        end
      end
    end
  end

  // Second formulation of the choice: no eligible source may outrank the
  // winner, either by a higher level or by a lower number at its level
  always_comb begin
    beaten = 1'b0;
    for (int j = 0; j < IVPR_NUM_VEC; j++) begin
      if (win_found && valid[j] && lvl[2*j +: 2] >= core_mask_in) begin
        if (lvl[2*j +: 2] > win_lvl ||
            (lvl[2*j +: 2] == win_lvl && j < int'(win_vec))) begin
          beaten = 1'b1;
        end
      end
    end
  end

  // Entries 0 and 1 hold reset addresses at the internal reset base, or at the external one on a narrow external boot
  always_comb begin
    nxt_overlay = (vector_table_base_in == IVPR_RESET_BASE_INT) ||
      (ext_boot_in && !ext_address_width_select_in &&
       vector_table_base_in == IVPR_RESET_BASE_EXT);
  end

  // Presented request and its vector; recomputed every cycle, irq dropped in the cycle after an ack
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_ff <= 1'b0;
      vec_ff <= 7'h00;
      lvl_ff <= 2'h0;
    end else begin
      irq_ff <= win_found && !ack_in;
      vec_ff <= win_vec;
      lvl_ff <= win_lvl;
    end
  end

  // Fetch address: base plus two words per vector number
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addr_ff <= 21'h000000;
    end else begin
      addr_ff <= vector_table_base_in +
        IVPR_ADDR_W'({win_vec, 1'b0});
    end
  end

  // Programmed level of the winner as software wrote it, before any folding
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      raw_lvl_ff <= 2'h0;
    end else begin
      raw_lvl_ff <= prog_level_in[2*win_vec +: 2];
    end
  end

  // Overlay flag registered so it lines up with the address
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      overlay_ff <= 1'b0;
    end else begin
      overlay_ff <= nxt_overlay;
    end
  end

  assign irq_out = irq_ff;
  assign vector_out = vec_ff;
  assign level_out = lvl_ff;
  assign fetch_addr_out = addr_ff;
  assign reset_overlay_out = overlay_ff;

  // Checks tie presented outputs to the registered request set
  property p_fix3;
    @(posedge clk_in) disable iff (reset_in)
      (|req_in[5:2]) |=> (irq_out || $past(ack_in)) && level_out == 2'h3;
  endproperty
  a_fix3: assert property (p_fix3) else $error("core fault not at level 3");
  property p_addr;
    @(posedge clk_in) disable iff (reset_in)
      irq_out |-> fetch_addr_out == $past(vector_table_base_in) + 21'(2 * vector_out);
  endproperty
  a_addr: assert property (p_addr) else $error("fetch address not base plus 2n");
  property p_reserved;
    @(posedge clk_in) disable iff (reset_in)
      irq_out |-> !(vector_out inside {0, 1, 8, 12, 13, 19, 25, 36, 37, 44, 51, 70});
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved vector raised");
  property p_mask;
    @(posedge clk_in) disable iff (reset_in)
      irq_out |-> level_out >= $past(core_mask_in);
  endproperty
  a_mask: assert property (p_mask) else $error("request below mask presented");
  property p_order;
    @(posedge clk_in) disable iff (reset_in)
      (irq_out && vector_out > 7'h02) |-> !$past(req_in[2]);
  endproperty
  a_order: assert property (p_order) else $error("lower vector passed over");
  property p_silent;
    @(posedge clk_in) disable iff (reset_in)
      (req_in == '0) |=> !irq_out;
  endproperty
  a_silent: assert property (p_silent) else $error("request without a source");
  property p_width;
    @(posedge clk_in) disable iff (reset_in)
      irq_out |-> vector_out < 7'h56;
  endproperty
  a_width: assert property (p_width) else $error("vector beyond table");
  property p_overlay;
    @(posedge clk_in) disable iff (reset_in)
      ($past(vector_table_base_in) == 21'h000200) |-> reset_overlay_out;
  endproperty
  a_overlay: assert property (p_overlay) else $error("overlay not flagged");
  property p_overlay_ext;
    @(posedge clk_in) disable iff (reset_in)
      ($past(ext_boot_in) && !$past(ext_address_width_select_in) &&
       $past(vector_table_base_in) == 21'h000000) |-> reset_overlay_out;
  endproperty
  a_overlay_ext: assert property (p_overlay_ext) else $error("narrow boot overlay missed");
  property p_overlay_only;
    @(posedge clk_in) disable iff (reset_in)
      reset_overlay_out |-> ($past(vector_table_base_in) == 21'h000200 ||
        $past(vector_table_base_in) == 21'h000000);
  endproperty
  a_overlay_only: assert property (p_overlay_only) else $error("overlay at other base");
  // A winner that some eligible source outranks means the scan is broken
  property p_best;
    @(posedge clk_in) disable iff (reset_in)
      win_found |-> !beaten;
  endproperty
  a_best: assert property (p_best) else $error("winner outranked");
  // Debug sources carry their programmed level; zero must never show
  property p_dbg_level;
    @(posedge clk_in) disable iff (reset_in)
      (irq_out && ivpr_class(vector_out) == IVPR_CLS_DBG) |->
        (level_out != 2'h0 && level_out == raw_lvl_ff);
  endproperty
  a_dbg_level: assert property (p_dbg_level) else $error("debug level out of range");
  // Peripheral sources carry their programmed level; three must never show
  property p_per_level;
    @(posedge clk_in) disable iff (reset_in)
      (irq_out && ivpr_class(vector_out) == IVPR_CLS_PER) |->
        (level_out != 2'h3 && level_out == raw_lvl_ff);
  endproperty
  a_per_level: assert property (p_per_level) else $error("peripheral level out of range");
  // Software interrupts below the core faults sit at fixed levels
  property p_fixed_sw;
    @(posedge clk_in) disable iff (reset_in)
      irq_out |-> ((vector_out != 7'h0e || level_out == 2'h2) &&
        (vector_out != 7'h0f || level_out == 2'h1) &&
        (vector_out != 7'h51 || level_out == 2'h1) &&
        (vector_out != 7'h10 || level_out == 2'h0));
  endproperty
  a_fixed_sw: assert property (p_fixed_sw) else $error("fixed software level wrong");
endmodule // ivpr_resolver

// >>> bench/ivpr_core_model.sv
// Core model that takes presented vectors
`timescale 1ns/100ps
module ivpr_core_model (
  input wire logic clk_in,
  input wire logic irq_in,
  input wire logic take_en_in,
  output logic ack_out
);
  // Ack lasts one cycle, so the core never takes the same vector twice running
  always_ff @(posedge clk_in) begin
    ack_out <= take_en_in & irq_in & ~ack_out;
  end
endmodule // ivpr_core_model

// >>> bench/tb_top.sv
// Self-checking bench for the vector priority resolver
`timescale 1ns/100ps
module tb_top;
  import ivpr_pkg::*;
  logic clk = 0, rst = 1, eb = 0, es = 0, en = 0, ack, irq, ovl;
  logic [85:0] req = '0;
  logic [171:0] lvl = '1;
  logic [1:0] mask = '0, lo;
  logic [20:0] base = 21'h001000, fa;
  logic [6:0] vo;
  int error_cnt = 0, n_tests = 0, cyc = 0, i;
  ivpr_resolver dut_u (.clk_in(clk), .reset_in(rst), .req_in(req), .prog_level_in(lvl),
    .core_mask_in(mask), .vector_table_base_in(base), .ext_boot_in(eb),
    .ext_address_width_select_in(es), .ack_in(ack), .irq_out(irq), .vector_out(vo),
    .level_out(lo), .fetch_addr_out(fa), .reset_overlay_out(ovl));
  ivpr_core_model core_u (.clk_in(clk), .irq_in(irq), .take_en_in(en), .ack_out(ack));
  // Clock and a cycle ceiling so a hang still ends in the report
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Outputs land one edge after the inputs; two edges give settled values
  task automatic ob(input logic i, input logic [6:0] v, input logic [1:0] l);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 21'(i), 21'(irq));
    if (i) chk("vector", 21'(v), 21'(vo));
    if (i) chk("level", 21'(l), 21'(lo));
  endtask
  task automatic rq(input int v, input logic [1:0] l);
    req[v] <= 1'b1;
    lvl[2*v +: 2] <= l;
  endtask
  task automatic clr();
    req <= '0;
    lvl <= '1;
  endtask
  task automatic t_walk();
    @(posedge clk);
    rq(20, 2'h2);
    ob(1, 7'h14, 2'h2);
    chk("fetch", 21'h001028, fa);
    rq(21, 2'h2);
    en <= 1'b1;
    for (i = 0; i < 8 && ack !== 1'b1; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    chk("irq_after_ack", 21'h0, 21'(irq));
    en <= 1'b0;
    clr();
  endtask
  task automatic t_prio();
    rq(85, 2'h2);
    rq(24, 2'h1);
    rq(2, 2'h0);
    rq(6, 2'h3);
    ob(1, 7'h02, 2'h3);
    req[2] <= 1'b0;
    ob(1, 7'h06, 2'h3);
    req[6] <= 1'b0;
    ob(1, 7'h55, 2'h2);
    chk("fetch", 21'h0010aa, fa);
    rq(76, 2'h1);
    rq(75, 2'h1);
    req[85] <= 1'b0;
    ob(1, 7'h18, 2'h1);
    req[24] <= 1'b0;
    ob(1, 7'h4b, 2'h1);
    clr();
  endtask
  task automatic t_mask_resv();
    rq(8, 2'h2);
    rq(12, 2'h2);
    ob(0, 7'h0, 2'h0);
    rq(24, 2'h1);
    mask <= 2'h2;
    ob(0, 7'h0, 2'h0);
    mask <= 2'h1;
    ob(1, 7'h18, 2'h1);
    mask <= 2'h0;
    clr();
  endtask
  task automatic t_ovl();
    base <= 21'h000200;
    ob(0, 7'h0, 2'h0);
    chk("overlay", 21'h1, 21'(ovl));
    base <= 21'h000000;
    eb <= 1'b1;
    ob(0, 7'h0, 2'h0);
    chk("overlay", 21'h1, 21'(ovl));
    es <= 1'b1;
    ob(0, 7'h0, 2'h0);
    chk("overlay", 21'h0, 21'(ovl));
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset for three cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset_irq", 21'h0, 21'(irq));
    chk("reset_fetch", 21'h0, fa);
    t_walk();
    t_prio();
    t_mask_resv();
    t_ovl();
    summarize();
  end
endmodule // tb_top
